// [core/vipc_defines.svh]
// Purpose: Offsets, field positions, reset values and fixed figures of the
//          vectored interrupt priority controller.
// Assumes: Byte offsets on a 32-bit bus, one aligned word per register.
// Notes:   Definitions only; included by bare name.
//
// Operation
// R01: Traps use fixed vectors 1 to 4; alternate table adds 0x100.
// R02: Requests map to two-byte slots; request 65 at 0x000096.
// R03: Seventeen software-visible registers.
// R04: Control one holds nesting disable and trap status flags.
// R05: Control two sets pin edge polarity and alternate table.
// R06: A flag is set by its event and held until software clears it.
// R07: A flag interrupts only while its enable bit is set.
// R08: Each user source has a programmable priority of eight levels.
// R09: A pending interrupt latches its 7-bit vector and 4-bit new level.
// R10: Latched new level equals the reported interrupt's priority.
// R11: Flag, enable and priority bits follow vector table order from bit 0.
// R12: Low CPU level bits are status word bits 7:5, writable.
// R13: The fourth CPU level bit is read-only to software.
// R14: CPU level is the fourth bit above the lower three, 0 to 15.
// R15: CPU level 7 blocks every user interrupt.
// R16: Fourth level bit set blocks user interrupts; only traps remain.
// R17: Nesting disabled ignores writes to the low level bits.
// R18: Select bit 15 set picks the alternate table.
// R19: Nesting disabled stops a new interrupt preempting one in service; the code still lets traps preempt.
// R20: Lower vector number outranks a higher one in natural order.
// R21: Highest programmed level wins; ties go to the lowest request.
// R22: Present only a level above the current CPU level.
`ifndef VIPC_DEFINES_SVH
`define VIPC_DEFINES_SVH

// ****
// Register byte offsets
// ****
`define VIPC_OFF_GCTRL1   8'h00
`define VIPC_OFF_GCTRL2   8'h04
`define VIPC_OFF_FLAG0    8'h08
`define VIPC_OFF_FLAG1    8'h0C
`define VIPC_OFF_EN0      8'h10
`define VIPC_OFF_EN1      8'h14
`define VIPC_OFF_PRIO0    8'h18
`define VIPC_OFF_LATCH    8'h38
`define VIPC_OFF_STATUS   8'h3C
`define VIPC_OFF_CORE     8'h40

// ****
// Field positions
// ****
`define VIPC_BIT_NESTING_DISABLE   15
`define VIPC_BIT_DIV0     6
`define VIPC_BIT_TRAP0    1
`define VIPC_BIT_ALTSEL   15
`define VIPC_BIT_IPL_LO   5
`define VIPC_BIT_PSV      2

// ****
// Sizes, reset values and fixed figures
// ****
`define VIPC_NUM_SRC      32
`define VIPC_NUM_TRAP     4
`define VIPC_NUM_PRIO     8
`define VIPC_STK_DEPTH    8
`define VIPC_USER_VEC0    7'h08
`define VIPC_TRAP_TOP_LVL 4'hE
`define VIPC_SLOT_BASE    24'h00_0004
`define VIPC_ALT_OFFSET   24'h00_0100
`define VIPC_RST_REG16    16'h0000
`define VIPC_IPL_MAX_LO   3'h7
`define VIPC_EXT_SRC0     0
`define VIPC_EXT_SRC1     20
`define VIPC_EXT_SRC2     29

`endif

// [core/vipc_pkg.sv]
// Purpose: Types shared by the interrupt controller and its users.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Constants live in vipc_defines.svh.
`default_nettype none

package vipc_pkg;

    // Bus slave phase tracking
    typedef enum logic [1:0] {
        VIPC_BS_IDLE   = 2'b00,
        VIPC_BS_WRITE  = 2'b01,
        VIPC_BS_RDWAIT = 2'b10,
        VIPC_BS_RDDATA = 2'b11
    } vipc_bus_st_t;

    // Request presented to the processor core
    typedef struct packed {
        logic        req;
        logic [6:0]  vector;
        logic [3:0]  level;
        logic [23:0] addr;
    } vipc_cpu_req_t;

    // Trap event pulses from the core
    typedef struct packed {
        logic osc_fail;
        logic addr_err;
        logic stack_err;
        logic math_err;
        logic div0_err;
    } vipc_trap_evt_t;

endpackage

`default_nettype wire

// [core/vipc_top.sv]
// Purpose: Vectored, prioritised interrupt and trap controller with an AHB-Lite
//          register slave.
// Assumes: Single clock hclk; peripheral and trap events are one-cycle pulses on hclk.
// Notes:   External request pins are asynchronous and pass a three-stage synchroniser.
`include "vipc_defines.svh"
`default_nettype none

module vipc_top (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    // Event sources
    input  wire logic [31:0]            periph_evt,
    input  wire logic [2:0]             ext_pin,
    input  wire vipc_pkg::vipc_trap_evt_t trap_evt,
    input  wire logic                   disi_active,
    // Processor core
    input  wire logic                   cpu_ack,
    input  wire logic                   cpu_ret,
    output vipc_pkg::vipc_cpu_req_t     cpu_req,
    output logic [3:0]                  cpu_priority_level
);
    import vipc_pkg::*;

    // ****
    // Declarations
    // ****
    vipc_bus_st_t         bus_st_r;
    vipc_bus_st_t         bus_st_nxt;
    logic [7:0]           addr_r;
    logic                 hit_r;
    logic [31:0]          rdata_r;
    logic                 take;
    logic                 wr_en;
    logic [15:0]          wd;

    logic                 nesting_disable_r;
    logic [3:0]           trap_stat_r;
    logic                 div0_stat_r;
    logic                 alternate_table_select_r;
    logic [2:0]           edge_pol_r;
    logic [31:0]          request_flag_r;
    logic [31:0]          source_enable_r;
    logic [2:0]           prio_r [`VIPC_NUM_SRC];
    logic [6:0]           pending_vector_number_r;
    logic [3:0]           new_level_r;
    logic [2:0]           ipl_lo_r;
    logic                 cpu_priority_top_bit_r;
    logic [8:0]           status_misc_r;
    logic                 psv_r;
    logic [3:0]           trap_pend_r;
    logic [3:0]           stk_r [`VIPC_STK_DEPTH];
    logic [3:0]           sp_r;
    vipc_cpu_req_t        req_r;

    logic [2:0]           pin_s1_r;
    logic [2:0]           pin_s2_r;
    logic [2:0]           pin_s3_r;
    logic [2:0]           pin_edge;
    logic [31:0]          flag_set;

    logic [3:0]           cur_ipl;
    logic                 best_ok;
    logic [3:0]           best_lvl;
    logic [6:0]           best_vec;
    logic                 present;
    logic                 ack_take;
    logic                 ret_take;
    logic                 in_service;
    logic [15:0]          rd_val;

    function automatic logic wsel(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ****
    // AHB-Lite slave: writes take no wait state, reads take one
    // ****
    assign take       = hsel && htrans[1] && hready;
    assign wr_en      = (bus_st_r == VIPC_BS_WRITE) && hit_r;
    assign wd         = hwdata[15:0];
    assign hreadyout  = (bus_st_r != VIPC_BS_RDWAIT);
    assign hresp      = 1'b0;
    assign hrdata     = rdata_r;

    always_comb begin
        unique case (bus_st_r)
            VIPC_BS_RDWAIT: bus_st_nxt = VIPC_BS_RDDATA;
            VIPC_BS_IDLE,
            VIPC_BS_WRITE,
            VIPC_BS_RDDATA: begin
                if (take) begin
                    bus_st_nxt = hwrite ? VIPC_BS_WRITE : VIPC_BS_RDWAIT;
                end else begin
                    bus_st_nxt = VIPC_BS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st_r <= VIPC_BS_IDLE;
        end else begin
            bus_st_r <= bus_st_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 8'h00;
            hit_r  <= 1'b0;
        end else if (take) begin
            addr_r <= haddr[7:0];
            hit_r  <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
        end
    end

    // Read mux; unmapped words read as zero, see R03
    always_comb begin
        rd_val = `VIPC_RST_REG16;
        if (hit_r) begin
            unique case (addr_r)
                `VIPC_OFF_GCTRL1: rd_val = {nesting_disable_r, 8'h00, div0_stat_r, 1'b0,
                                            trap_stat_r[0], trap_stat_r[1],
                                            trap_stat_r[2], trap_stat_r[3], 1'b0};
                `VIPC_OFF_GCTRL2: rd_val = {alternate_table_select_r, disi_active,
                                            11'h000, edge_pol_r};   // see R05
                `VIPC_OFF_FLAG0:  rd_val = request_flag_r[15:0];
                `VIPC_OFF_FLAG1:  rd_val = request_flag_r[31:16];
                `VIPC_OFF_EN0:    rd_val = source_enable_r[15:0];
                `VIPC_OFF_EN1:    rd_val = source_enable_r[31:16];
                `VIPC_OFF_LATCH:  rd_val = {4'h0, new_level_r, 1'b0, pending_vector_number_r};
                `VIPC_OFF_STATUS: rd_val = {7'h00, status_misc_r[8], ipl_lo_r, 1'b0,
                                            status_misc_r[3:0]}; // see R12
                `VIPC_OFF_CORE:   rd_val = {12'h000, cpu_priority_top_bit_r, psv_r, 2'b00};
                default: begin
                    for (int n = 0; n < `VIPC_NUM_PRIO; n++) begin
                        if (addr_r == 8'(`VIPC_OFF_PRIO0 + 4 * n)) begin
                            rd_val = {1'b0, prio_r[4*n+3], 1'b0, prio_r[4*n+2],
                                      1'b0, prio_r[4*n+1], 1'b0, prio_r[4*n]}; // see R11
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (bus_st_r == VIPC_BS_RDWAIT) begin
            rdata_r <= {16'h0000, rd_val};
        end
    end

    // ****
    // External request pins: three-stage synchroniser and edge detect
    // ****
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            pin_s3_r <= 3'h0;
        end else begin
            pin_s1_r <= ext_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Polarity 1 takes a falling edge, 0 a rising edge
    assign pin_edge = (pin_s2_r ^ pin_s3_r) & (pin_s2_r ^ edge_pol_r);

    always_comb begin
        flag_set                 = periph_evt;
        flag_set[`VIPC_EXT_SRC0] = periph_evt[`VIPC_EXT_SRC0] | pin_edge[0];
        flag_set[`VIPC_EXT_SRC1] = periph_evt[`VIPC_EXT_SRC1] | pin_edge[1];
        flag_set[`VIPC_EXT_SRC2] = periph_evt[`VIPC_EXT_SRC2] | pin_edge[2];
    end

    // ****
    // Global control registers
    // ****
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nesting_disable_r <= 1'b0;
            trap_stat_r       <= 4'h0;
            div0_stat_r       <= 1'b0;
        end else begin
            if (wr_en && wsel(addr_r, `VIPC_OFF_GCTRL1)) begin
                nesting_disable_r <= wd[`VIPC_BIT_NESTING_DISABLE]; // see R04
                trap_stat_r <= {wd[`VIPC_BIT_TRAP0], wd[`VIPC_BIT_TRAP0+1],
                                wd[`VIPC_BIT_TRAP0+2], wd[`VIPC_BIT_TRAP0+3]}
                               | {trap_evt.osc_fail, trap_evt.stack_err,
                                  trap_evt.addr_err, trap_evt.math_err};
                div0_stat_r <= wd[`VIPC_BIT_DIV0] | trap_evt.div0_err;
            end else begin
                trap_stat_r <= trap_stat_r | {trap_evt.osc_fail, trap_evt.stack_err,
                                              trap_evt.addr_err, trap_evt.math_err};
                div0_stat_r <= div0_stat_r | trap_evt.div0_err;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alternate_table_select_r <= 1'b0;
            edge_pol_r               <= 3'h0;
        end else if (wr_en && wsel(addr_r, `VIPC_OFF_GCTRL2)) begin
            alternate_table_select_r <= wd[`VIPC_BIT_ALTSEL]; // see R18
            edge_pol_r               <= wd[2:0]; // see R05
        end
    end

    // ****
    // Source flags, enables and priorities
    // ****
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            request_flag_r <= 32'h0000_0000;
        end else begin
            // Event in the clearing cycle still sets the flag
            if (wr_en && wsel(addr_r, `VIPC_OFF_FLAG0)) begin
                request_flag_r <= {request_flag_r[31:16], wd} | flag_set; // see R06
            end else if (wr_en && wsel(addr_r, `VIPC_OFF_FLAG1)) begin
                request_flag_r <= {wd, request_flag_r[15:0]} | flag_set; // see R06
            end else begin
                request_flag_r <= request_flag_r | flag_set; // see R06
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            source_enable_r <= 32'h0000_0000;
        end else if (wr_en && wsel(addr_r, `VIPC_OFF_EN0)) begin
            source_enable_r[15:0] <= wd; // see R11
        end else if (wr_en && wsel(addr_r, `VIPC_OFF_EN1)) begin
            source_enable_r[31:16] <= wd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int s = 0; s < `VIPC_NUM_SRC; s++) begin
                prio_r[s] <= 3'h0;
            end
        end else if (wr_en) begin
            for (int n = 0; n < `VIPC_NUM_PRIO; n++) begin
                if (addr_r == 8'(`VIPC_OFF_PRIO0 + 4 * n)) begin
                    for (int j = 0; j < 4; j++) begin
                        prio_r[4*n+j] <= wd[4*j +: 3]; // see R08
                    end
                end
            end
        end
    end

    // ****
    // Arbitration over traps and user sources
    // ****
    assign cur_ipl            = {cpu_priority_top_bit_r, ipl_lo_r}; // see R14
    assign cpu_priority_level = cur_ipl;
    assign in_service         = (sp_r != 4'h0);

    always_comb begin
        best_ok  = 1'b0;
        best_lvl = 4'h0;
        best_vec = 7'h00;
        // Descending scan with >= leaves the lowest vector on a tie
        for (int k = `VIPC_NUM_SRC - 1; k >= 0; k--) begin
            if (request_flag_r[k] && source_enable_r[k] && // see R07
                (!best_ok || {1'b0, prio_r[k]} >= best_lvl)) begin // see R21
                best_ok  = 1'b1;
                best_lvl = {1'b0, prio_r[k]};
                best_vec = 7'(`VIPC_USER_VEC0 + k); // see R11
            end
        end
        for (int t = `VIPC_NUM_TRAP - 1; t >= 0; t--) begin
            if (trap_pend_r[t]) begin // see R20
                best_ok  = 1'b1;
                best_lvl = 4'(`VIPC_TRAP_TOP_LVL - t);
                best_vec = 7'(t + 1); // see R01
            end
        end
    end

    // User levels never exceed 7, so level 7 or a set top bit masks them
    assign present = best_ok && (best_lvl > cur_ipl) &&                     // see R22 R15 R16
                     (best_lvl[3] || !(nesting_disable_r && in_service));   // see R19

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending_vector_number_r <= 7'h00;
            new_level_r             <= 4'h0;
        end else if (best_ok) begin
            pending_vector_number_r <= best_vec; // see R09
            new_level_r             <= best_lvl; // see R10
        end
    end

    // ****
    // Request to the core, registered
    // ****
    assign ack_take = cpu_ack && req_r.req;
    assign ret_take = cpu_ret && in_service && !ack_take;
    assign cpu_req  = req_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else begin
            // Drop for one cycle after an ack so the raised level settles
            req_r.req    <= present && !ack_take;
            req_r.vector <= best_vec;
            req_r.level  <= best_lvl;
            req_r.addr   <= (alternate_table_select_r ? `VIPC_ALT_OFFSET : 24'h00_0000)
                            + `VIPC_SLOT_BASE + {16'h0000, best_vec, 1'b0}; // see R02 R18
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_pend_r <= 4'h0;
        end else begin
            for (int t = 0; t < `VIPC_NUM_TRAP; t++) begin
                if (ack_take && req_r.vector == 7'(t + 1)) begin
                    trap_pend_r[t] <= 1'b0;
                end
            end
            // A new trap event wins over the clear by the ack
            if (trap_evt.osc_fail)  trap_pend_r[0] <= 1'b1;
            if (trap_evt.addr_err)  trap_pend_r[1] <= 1'b1;
            if (trap_evt.stack_err) trap_pend_r[2] <= 1'b1;
            if (trap_evt.math_err)  trap_pend_r[3] <= 1'b1;
        end
    end

    // ****
    // CPU priority level, level stack and status words
    // ****
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ipl_lo_r               <= 3'h0;
            cpu_priority_top_bit_r <= 1'b0;
        end else if (ack_take) begin
            cpu_priority_top_bit_r <= req_r.level[3];
            ipl_lo_r <= (nesting_disable_r && !req_r.level[3]) ?
                        `VIPC_IPL_MAX_LO : req_r.level[2:0]; // see R19
        end else if (ret_take) begin
            cpu_priority_top_bit_r <= stk_r[3'(sp_r - 4'h1)][3];
            ipl_lo_r               <= stk_r[3'(sp_r - 4'h1)][2:0];
        end else if (wr_en && wsel(addr_r, `VIPC_OFF_STATUS) && !nesting_disable_r) begin
            ipl_lo_r <= wd[`VIPC_BIT_IPL_LO +: 3]; // see R12 R17
        end
        // Top bit has no software write path at all; see R13
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_r <= 4'h0;
            for (int d = 0; d < `VIPC_STK_DEPTH; d++) begin
                stk_r[d] <= 4'h0;
            end
        end else if (ack_take && sp_r != 4'(`VIPC_STK_DEPTH)) begin
            stk_r[3'(sp_r)] <= cur_ipl;
            sp_r            <= sp_r + 4'h1;
        end else if (ret_take) begin
            sp_r <= sp_r - 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_misc_r <= 9'h000;
            psv_r         <= 1'b0;
        end else begin
            if (wr_en && wsel(addr_r, `VIPC_OFF_STATUS)) begin
                status_misc_r <= {wd[8], 4'h0, wd[3:0]};
            end
            if (wr_en && wsel(addr_r, `VIPC_OFF_CORE)) begin
                psv_r <= wd[`VIPC_BIT_PSV];
            end
        end
    end

    // hsize is accepted but only whole-word writes are meaningful
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, hwdata[31:16], status_misc_r[7:4]};

endmodule

`default_nettype wire

// [tb/vipc_properties.sv]
// Purpose: Port checks for vipc_top
// Assumes: One clock, hresetn asynchronous and active low
// Notes:   Bound into every vipc_top instance
`default_nettype none
module vipc_checker (
    input wire logic                    hclk, hresetn, hsel, hwrite, hready, hreadyout,
    input wire logic                    cpu_ack, cpu_ret,
    input wire logic [1:0]              htrans,
    input wire vipc_pkg::vipc_cpu_req_t cpu_req,
    input wire logic [3:0]              cpu_priority_level
);
    import vipc_pkg::*;
    wire logic rq = cpu_req.req;
    // ****
    // Properties
    // ****
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_SLOT: assert property (rq |-> (cpu_req.addr & ~24'h00_0100) == 24'h00_0004 +
        {cpu_req.vector, 1'b0}) else $error("vector slot address wrong");
    AST_TRAP: assert property (rq && cpu_req.vector < 7'h08 |-> cpu_req.vector inside {[1:4]}
        && cpu_req.level == 4'hF - cpu_req.vector[3:0]) else $error("trap vector or level wrong");
    AST_USER: assert property (rq && cpu_req.vector >= 7'h08 |-> !cpu_req.level[3]
        && cpu_req.vector < 7'h28) else $error("user request out of range");
    AST_ABOVE: assert property (rq |-> cpu_req.level > $past(cpu_priority_level))
        else $error("request not above cpu level");
    AST_TOP_BLOCKS: assert property (rq && $past(cpu_priority_level[3]) |-> cpu_req.vector < 7'h08)
        else $error("user request while top level bit set");
    AST_SEVEN: assert property (rq && $past(cpu_priority_level) == 4'h7 |-> cpu_req.vector < 7'h08)
        else $error("user request at cpu level 7");
    AST_ACK_LEVEL: assert property (cpu_ack && rq && !cpu_ret |=> !rq &&
        cpu_priority_level >= $past(cpu_req.level)) else $error("level after take wrong");
    AST_TOP_STEADY: assert property (!(cpu_ack && rq) && !cpu_ret |=>
        $stable(cpu_priority_level[3])) else $error("top level bit moved without take or return");
    AST_READ_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait state wrong");
endmodule
bind vipc_top vipc_checker chk (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout, .cpu_ack,
    .cpu_ret, .htrans, .cpu_req, .cpu_priority_level);
`default_nettype wire

// [tb/vipc_core_model.sv]
// Purpose: Processor core that takes and returns interrupts
// Assumes: lag adds wait cycles before a take
// Notes:   ret_go from the bench asks for a return
`default_nettype none
module vipc_core_model (
    input  wire logic                    hclk, hresetn, ret_go,
    input  wire logic [1:0]              lag,
    input  wire vipc_pkg::vipc_cpu_req_t cpu_req,
    output logic                         cpu_ack, cpu_ret
);
    import vipc_pkg::*;
    logic [1:0] wait_r;
    // ****
    // Take and return
    // ****
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {cpu_ack, cpu_ret, wait_r} <= 4'h0;
        end else begin
            cpu_ret <= ret_go;
            cpu_ack <= cpu_req.req && !cpu_ack && wait_r >= lag;
            wait_r  <= (cpu_req.req && !cpu_ack && wait_r < lag) ? wait_r + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

// [tb/vipc_top_tb.sv]
// Purpose: Self-checking bench for vipc_top
// Assumes: Single-word AHB-Lite transfers; core model on the far side
// Notes:   Expected requests queue up and are checked at each take
`default_nettype none
module vipc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vipc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_ack, cpu_ret, ret_go;
    logic [31:0] haddr, hwdata, hrdata, periph_evt, seed;
    logic [1:0] htrans, lag;
    logic [2:0] pr, pins;
    logic [3:0] cpu_priority_level;
    logic [7:0] offs[9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h38, 8'h3C, 8'h40, 8'h80};
    vipc_trap_evt_t trap_evt;
    vipc_cpu_req_t cpu_req;
    logic [35:0] expq[$];
    int miscompares, compares;
    vipc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .periph_evt, .ext_pin(pins), .trap_evt,
        .disi_active(1'b0), .cpu_ack, .cpu_ret, .cpu_req, .cpu_priority_level);
    vipc_core_model core (.hclk, .hresetn, .ret_go, .lag, .cpu_req, .cpu_ack, .cpu_ret);
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
        int n;
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h00_0000, a};
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= {16'h0000, d};
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
        if (!w) check("read data", {4'h0, hrdata}, {20'h0_0000, e});
        check("hresp", {35'h0, hresp}, 36'h0);
    endtask
    task automatic note(input int src, input logic [3:0] lvl, input logic [23:0] base);
        expq.push_back({1'b1, 7'(src + 8), lvl, base + 24'(2 * src + 20)});
    endtask
    task automatic pulse(input logic [31:0] m, input int hold);
        periph_evt <= m;
        @(posedge hclk);
        periph_evt <= 32'h0000_0000;
        repeat (hold) @(posedge hclk);
    endtask
    // Waits for a take, checks the new level, then clears the cause by a bus write
    task automatic serve(input logic [7:0] a, input logic [15:0] d, input logic [3:0] lvl);
        int n;
        n = 0;
        do begin @(posedge hclk); n++; end while (!(cpu_ack === 1'b1 && cpu_req.req === 1'b1) && n < 60);
        @(posedge hclk);
        check("cpu level", {32'h0, cpu_priority_level}, {32'h0, lvl});
        bus(1'b1, a, d, 16'h0000);
    endtask
    task automatic back;
        ret_go <= 1'b1;
        @(posedge hclk);
        ret_go <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    always @(posedge hclk) if (cpu_ack === 1'b1 && cpu_req.req === 1'b1)
        check("cpu_req", cpu_req, expq.size() > 0 ? expq.pop_front() : 36'h0_0000_0000);
    initial begin
        #40000;
        miscompares++;
        wrap_up;
    end
    // ****
    // Scenarios
    // ****
    initial begin
        {hresetn, hsel, hwrite, ret_go, htrans, lag} = 8'h00;
        {haddr, hwdata, periph_evt, pins} = 99'h0;
        trap_evt = 5'h00;
        seed = 32'h0000_2172;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (offs[i]) bus(1'b0, offs[i], 16'h0000, 16'h0000);
        bus(1'b1, 8'h10, 16'h003E, 0); bus(1'b1, 8'h18, 16'h5660, 0); bus(1'b1, 8'h1C, 16'h0003, 0);
        note(3, 4'h5, 0); pulse(32'h8, 0); serve(8'h08, 0, 4'h5); back;
        note(1, 4'h6, 0); note(2, 4'h6, 0); note(4, 4'h3, 0); pulse(32'h16, 0);
        serve(8'h08, 16'h0014, 4'h6); back; serve(8'h08, 16'h0010, 4'h6); back;
        serve(8'h08, 0, 4'h3); back;
        bus(1'b1, 8'h3C, 16'h00E0, 0); note(3, 4'h5, 0); pulse(32'h8, 10);
        check("blocked at 7", cpu_req.req, 0); bus(1'b0, 8'h38, 0, 16'h050B);
        bus(1'b0, 8'h3C, 0, 16'h00E0); bus(1'b1, 8'h3C, 0, 0); serve(8'h08, 0, 4'h5); back;
        bus(1'b1, 8'h04, 16'h8000, 0); note(3, 4'h5, 24'h00_0100); pulse(32'h8, 0);
        serve(8'h08, 0, 4'h5); back; bus(1'b1, 8'h04, 0, 0);
        expq.push_back({1'b1, 7'h01, 4'hE, 24'h00_0006}); trap_evt.osc_fail <= 1'b1;
        @(posedge hclk); trap_evt <= 5'h00; serve(8'h40, 0, 4'hE);
        bus(1'b0, 8'h40, 0, 16'h0008); bus(1'b0, 8'h00, 0, 16'h0002);
        note(3, 4'h5, 0); pulse(32'h8, 10); check("trap level", cpu_req.req, 0);
        bus(1'b1, 8'h00, 0, 0); back; serve(8'h08, 0, 4'h5); back;
        bus(1'b1, 8'h00, 16'h8000, 0); bus(1'b1, 8'h3C, 16'h0060, 0); bus(1'b0, 8'h3C, 0, 0);
        note(3, 4'h5, 0); pulse(32'h8, 0); serve(8'h08, 0, 4'h7); back; bus(1'b1, 8'h00, 0, 0);
        repeat (4) begin
            seed = xs(seed);
            lag <= seed[1:0];
            pr = 3'(seed[4:2] % 3'h7) + 3'h1;
            bus(1'b1, 8'h1C, {9'h000, pr, 4'h3}, 0); note(5, {1'b0, pr}, 0); pulse(32'h20, 0);
            serve(8'h08, 0, {1'b0, pr}); back;
        end
        bus(1'b1, 8'h10, 0, 0); pulse(32'h8, 10); check("disabled", cpu_req.req, 0);
        pins <= 3'h1; repeat (5) @(posedge hclk);
        bus(1'b0, 8'h08, 0, 16'h0009);
        wrap_up;
    end
endmodule
`default_nettype wire
